// ---- inc/dabc_consts.svh ----
// Purpose: constants of the dual bus output control
// Assumes: included by bare name
// Notes: offsets are word addresses of the plain port
`ifndef DABC_CONSTS_SVH
`define DABC_CONSTS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define DABC_OFS_CTRL 4'h0
`define DABC_OFS_GAIN 4'h1
`define DABC_OFS_STAT 4'h2
`define DABC_CTRL_RST 5'h00
`define DABC_GAIN_RST 5'h00
`define DABC_GAIN_A_LSB 0
`define DABC_GAIN_B_LSB 8
`define DABC_STAT_STANDBY_IN 0
`define DABC_STAT_OEN 1
`define DABC_STAT_REFPD 2
// ----------------------------------------
// timing
// ----------------------------------------
`define DABC_LAT_LONG 8
`define DABC_LAT_SHORT 4
`define DABC_LAT_SKEW 9
`define DABC_PIPE_DEPTH 9
// gain step in units of 0.0001 db
`define DABC_GAIN_STEP_UDB 5826
`endif

// ---- inc/dabc_pkg.sv ----
// Purpose: types of the dual bus output control
// Assumes: nothing
// Notes: cfg bit order matches the control register
package dabc_pkg;
  typedef struct packed {
    logic rate80;
    logic skew;
    logic tmode;
    logic both_ch;
    logic dual_bus;
  } dabc_cfg_t;
  typedef struct packed {
    logic oe;
    logic [9:0] data;
  } dabc_bus_t;
endpackage

// ---- rtl/dabc_top.sv ----
// Purpose: output buses, latch clocks and gain codes of a dual converter
// Assumes: clk_i register side, smp_clk_i converter sample clock
// Notes: config crosses as quasi-static levels; change it while idle
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "dabc_consts.svh"
// Notes on behaviour
// - primary bus carries both channels or channel one only, bit 9 msb
// - primary bus fully high impedance during power-down
// - dual-bus mode drives second channel words on secondary bus
// - secondary bus high impedance in power-down and single-bus mode
// - low output enable turns on data and latch clock drivers
// - latch clock for capture, tri-stated during power-down
// - inverted latch clock also given, tri-stated during power-down
// - sample every edge at 40 mhz, every second edge at 80 mhz
// - each channel gain is a 5-bit code, 0.5826 db per step
// - high standby input powers down, outputs go high impedance
// - latency 8 or 4 by mode; with skew option 8 and 9
module dabc_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic [4:0] gain_a_o,
  output logic [4:0] gain_b_o,
  input wire logic reference_powerdown_in_i,
  input wire logic smp_clk_i,
  input wire logic standby_in_i,
  input wire logic out_en_n_i,
  input wire logic [9:0] chan_a_i,
  input wire logic [9:0] chan_b_i,
  output logic [9:0] primary_out_bus_o,
  output logic primary_out_bus_oe_o,
  output logic [9:0] secondary_out_bus_o,
  output logic secondary_out_bus_oe_o,
  output logic output_latch_clock_o,
  output logic output_latch_clock_n_o,
  output logic output_latch_clock_oe_o
);
  // ----------------------------------------
  // register side
  // ----------------------------------------
  dabc_pkg::dabc_cfg_t ctrl_reg, ctrl_next;
  logic [4:0] gain_a_reg, gain_a_next;
  logic [4:0] gain_b_reg, gain_b_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [1:0] st_s1_reg, st_s2_reg;
  logic refpd_s1_reg, refpd_s2_reg;
  logic standby_in_s1_reg, standby_in_s2_reg;
  logic oen_s1_reg, oen_s2_reg;
  always_comb begin
    ctrl_next = ctrl_reg;
    gain_a_next = gain_a_reg;
    gain_b_next = gain_b_reg;
    rdata_next = 16'h0000;
    if (wr_i && addr_i == `DABC_OFS_CTRL) begin
      ctrl_next = wdata_i[4:0];
    end
    if (wr_i && addr_i == `DABC_OFS_GAIN) begin
      gain_a_next = wdata_i[`DABC_GAIN_A_LSB +: 5];
      gain_b_next = wdata_i[`DABC_GAIN_B_LSB +: 5];
    end
    if (rd_i) begin
      unique case (addr_i)
        `DABC_OFS_CTRL: rdata_next = {11'h000, ctrl_reg};
        `DABC_OFS_GAIN: rdata_next = {3'h0, gain_b_reg, 3'h0, gain_a_reg};
        `DABC_OFS_STAT: rdata_next = {13'h0000, refpd_s2_reg, st_s2_reg};
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= `DABC_CTRL_RST;
      gain_a_reg <= `DABC_GAIN_RST;
      gain_b_reg <= `DABC_GAIN_RST;
      rdata_reg <= 16'h0000;
      st_s1_reg <= 2'h0;
      st_s2_reg <= 2'h0;
      refpd_s1_reg <= 1'b0;
      refpd_s2_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      gain_a_reg <= gain_a_next;
      gain_b_reg <= gain_b_next;
      rdata_reg <= rdata_next;
      st_s1_reg <= {oen_s2_reg, standby_in_s2_reg};
      st_s2_reg <= st_s1_reg;
      refpd_s1_reg <= reference_powerdown_in_i;
      refpd_s2_reg <= refpd_s1_reg;
    end
  end

  assign rdata_o = rdata_reg;
  assign gain_a_o = gain_a_reg;
  assign gain_b_o = gain_b_reg;

  // ----------------------------------------
  // crossing into the sample clock
  // ----------------------------------------
  logic lrst_s1_reg, lrst_n;
  dabc_pkg::dabc_cfg_t cfg_s1_reg, cfg_l;

  // reset and pins pass two flops; nothing else reads the first
  always_ff @(posedge smp_clk_i) begin
    lrst_s1_reg <= rst_n_i;
    lrst_n <= lrst_s1_reg;
    cfg_s1_reg <= ctrl_reg;
    cfg_l <= cfg_s1_reg;
    standby_in_s1_reg <= standby_in_i;
    standby_in_s2_reg <= standby_in_s1_reg;
    oen_s1_reg <= out_en_n_i;
    oen_s2_reg <= oen_s1_reg;
  end

  // ----------------------------------------
  // sampling and latency pipeline
  // ----------------------------------------
  logic smp_en_reg, smp_en_next;
  logic [9:0] a_hold_reg, a_hold_next;
  logic [9:0] b_hold_reg, b_hold_next;
  logic [9:0] a_pipe [0:`DABC_PIPE_DEPTH-1];
  logic [9:0] b_pipe [0:`DABC_PIPE_DEPTH-1];
  logic [9:0] a_tap, b_tap;

  always_comb begin
    // 80 mhz clock takes every second edge only
    smp_en_next = cfg_l.rate80 ? !smp_en_reg : 1'b1;
    a_hold_next = smp_en_reg ? chan_a_i : a_hold_reg;
    b_hold_next = smp_en_reg ? chan_b_i : b_hold_reg;
  end

  always_ff @(posedge smp_clk_i) begin
    if (!lrst_n) begin
      smp_en_reg <= 1'b1;
      a_hold_reg <= 10'h000;
      b_hold_reg <= 10'h000;
      a_pipe[0] <= 10'h000;
      b_pipe[0] <= 10'h000;
    end else begin
      smp_en_reg <= smp_en_next;
      a_hold_reg <= a_hold_next;
      b_hold_reg <= b_hold_next;
      a_pipe[0] <= a_hold_reg;
      b_pipe[0] <= b_hold_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < `DABC_PIPE_DEPTH; gi++) begin : g_pipe
      always_ff @(posedge smp_clk_i) begin
        if (!lrst_n) begin
          a_pipe[gi] <= 10'h000;
          b_pipe[gi] <= 10'h000;
        end else begin
          a_pipe[gi] <= a_pipe[gi-1];
          b_pipe[gi] <= b_pipe[gi-1];
        end
      end
    end
  endgenerate

  // tap k holds the sample k+1 cycles old
  always_comb begin
    if (cfg_l.skew) begin
      a_tap = a_pipe[`DABC_LAT_LONG-1];
      b_tap = b_pipe[`DABC_LAT_SKEW-1];
    end else if (cfg_l.tmode) begin
      a_tap = a_pipe[`DABC_LAT_SHORT-1];
      b_tap = b_pipe[`DABC_LAT_SHORT-1];
    end else begin
      a_tap = a_pipe[`DABC_LAT_LONG-1];
      b_tap = b_pipe[`DABC_LAT_LONG-1];
    end
  end

  // ----------------------------------------
  // output buses and latch clocks
  // ----------------------------------------
  dabc_pkg::dabc_bus_t pri_reg, pri_next;
  dabc_pkg::dabc_bus_t sec_reg, sec_next;
  logic lclk_reg, lclk_next;
  logic lclkn_reg, lclkn_next;
  logic lclk_oe_reg, lclk_oe_next;
  logic wsel_reg, wsel_next;
  logic drive_en, upd;

  always_comb begin
    drive_en = !standby_in_s2_reg && !oen_s2_reg;
    // data moves as the latch clock falls; receiver takes it rising
    upd = lclk_reg;
    lclk_next = !lclk_reg;
    lclkn_next = lclk_reg;
    lclk_oe_next = drive_en;
    pri_next.oe = drive_en;
    sec_next.oe = drive_en && cfg_l.dual_bus;
    pri_next.data = pri_reg.data;
    sec_next.data = sec_reg.data;
    wsel_next = wsel_reg;
    if (upd) begin
      if (cfg_l.both_ch && !cfg_l.dual_bus) begin
        pri_next.data = wsel_reg ? b_tap : a_tap;
        wsel_next = !wsel_reg;
      end else begin
        pri_next.data = a_tap;
        wsel_next = 1'b0;
      end
      // idle secondary words still track, hidden by the enable
      sec_next.data = b_tap;
    end
  end

  always_ff @(posedge smp_clk_i) begin
    if (!lrst_n) begin
      pri_reg <= '0;
      sec_reg <= '0;
      lclk_reg <= 1'b0;
      lclkn_reg <= 1'b1;
      lclk_oe_reg <= 1'b0;
      wsel_reg <= 1'b0;
    end else begin
      pri_reg <= pri_next;
      sec_reg <= sec_next;
      lclk_reg <= lclk_next;
      lclkn_reg <= lclkn_next;
      lclk_oe_reg <= lclk_oe_next;
      wsel_reg <= wsel_next;
    end
  end

  assign primary_out_bus_o = pri_reg.data;
  assign primary_out_bus_oe_o = pri_reg.oe;
  assign secondary_out_bus_o = sec_reg.data;
  assign secondary_out_bus_oe_o = sec_reg.oe;
  assign output_latch_clock_o = lclk_reg;
  assign output_latch_clock_n_o = lclkn_reg;
  assign output_latch_clock_oe_o = lclk_oe_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_pri_hiz;
    @(posedge smp_clk_i) disable iff (!lrst_n)
    standby_in_s2_reg |=> !primary_out_bus_oe_o && !output_latch_clock_oe_o;
  endproperty
  a_pri_hiz: assert property (p_pri_hiz)
    else $error("primary bus driven in power-down");

  property p_sec_hiz;
    @(posedge smp_clk_i) disable iff (!lrst_n)
    (standby_in_s2_reg || !cfg_l.dual_bus) |=> !secondary_out_bus_oe_o;
  endproperty
  a_sec_hiz: assert property (p_sec_hiz)
    else $error("secondary bus driven when it must float");

  property p_oe_on;
    @(posedge smp_clk_i) disable iff (!lrst_n)
    (!standby_in_s2_reg && !oen_s2_reg) |=>
      primary_out_bus_oe_o && output_latch_clock_oe_o;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("drivers off although enabled");

  property p_lclk_run;
    @(posedge smp_clk_i) disable iff (!lrst_n)
    output_latch_clock_o |=> !output_latch_clock_o ##1 output_latch_clock_o;
  endproperty
  a_lclk_run: assert property (p_lclk_run)
    else $error("latch clock not toggling");

  property p_lclk_inv;
    @(posedge smp_clk_i) disable iff (!lrst_n)
    lrst_n |-> output_latch_clock_n_o != output_latch_clock_o;
  endproperty
  a_lclk_inv: assert property (p_lclk_inv)
    else $error("inverted latch clock not complementary");

  property p_rate80;
    @(posedge smp_clk_i) disable iff (!lrst_n)
    (cfg_l.rate80 && smp_en_reg) |=> !smp_en_reg;
  endproperty
  a_rate80: assert property (p_rate80)
    else $error("80 mhz sampling on consecutive edges");

  property p_lat_short;
    @(posedge smp_clk_i) disable iff (!lrst_n)
    (cfg_l.tmode && !cfg_l.skew) |-> a_tap == $past(a_hold_reg, 4);
  endproperty
  a_lat_short: assert property (p_lat_short)
    else $error("mode 1 latency not 4");

  property p_lat_skew;
    @(posedge smp_clk_i) disable iff (!lrst_n)
    cfg_l.skew |-> b_tap == $past(b_hold_reg, 9);
  endproperty
  a_lat_skew: assert property (p_lat_skew)
    else $error("skewed second channel latency not 9");

  property p_pri_a;
    @(posedge smp_clk_i) disable iff (!lrst_n)
    (upd && !cfg_l.both_ch) |=> primary_out_bus_o == $past(a_tap);
  endproperty
  a_pri_a: assert property (p_pri_a)
    else $error("primary bus lost first channel word");

  property p_sec_b;
    @(posedge smp_clk_i) disable iff (!lrst_n)
    upd |=> secondary_out_bus_o == $past(b_tap);
  endproperty
  a_sec_b: assert property (p_sec_b)
    else $error("secondary bus lost second channel word");

  property p_alt;
    @(posedge smp_clk_i) disable iff (!lrst_n)
    (upd && cfg_l.both_ch && !cfg_l.dual_bus) |=> wsel_reg != $past(wsel_reg);
  endproperty
  a_alt: assert property (p_alt)
    else $error("single bus words not alternating");

  property p_gain;
    @(posedge clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `DABC_OFS_GAIN) |=>
      gain_b_o == $past(wdata_i[`DABC_GAIN_B_LSB +: 5]);
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain code not taken");

  c_dual: cover property (@(posedge smp_clk_i) disable iff (!lrst_n)
    secondary_out_bus_oe_o && primary_out_bus_oe_o);
  c_alt: cover property (@(posedge smp_clk_i) disable iff (!lrst_n)
    upd && wsel_reg && primary_out_bus_oe_o);
  c_standby_in: cover property (@(posedge smp_clk_i) disable iff (!lrst_n)
    $rose(standby_in_s2_reg));
endmodule
`default_nettype wire

// ---- testbench/dabc_capture.sv ----
// Purpose: capture logic at the far side of the output buses
// Assumes: words are settled at the rising latch clock edge
// Notes: captures only while the drivers are on
`timescale 1ns/1ps
`default_nettype none
module dabc_capture (
  input wire logic want_i,
  output logic out_en_n_o,
  input wire logic lclk_i,
  input wire logic lclk_oe_i,
  input wire dabc_pkg::dabc_bus_t pri_i,
  input wire dabc_pkg::dabc_bus_t sec_i,
  output logic [9:0] cap_p_o,
  output logic [9:0] cap_s_o,
  output logic [7:0] cnt_o
);
  // receiver pulls enable low to get data
  assign out_en_n_o = ~want_i;
  initial begin
    cap_p_o = 10'h000;
    cap_s_o = 10'h000;
    cnt_o = 8'h00;
  end
  // a floating latch clock must not capture, hence the enable gate
  always @(posedge lclk_i) begin
    if (lclk_oe_i && pri_i.oe) begin
      cap_p_o <= pri_i.data;
      cap_s_o <= sec_i.oe ? sec_i.data : ~cap_s_o;
      cnt_o <= cnt_o + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/dual_adc_output_bus_control_test.sv ----
// Purpose: self-checking bench of the dual bus output control
// Assumes: reads checked from a queue one cycle after the strobe
// Notes: link words checked after the pipeline has settled
`timescale 1ns/1ps
`default_nettype none
module dual_adc_output_bus_control_test;
  logic clk_i = 1'b0;
  logic smp = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wd = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic refpd = 1'b0;
  logic standby_in = 1'b0;
  logic want = 1'b1;
  logic oen_n;
  logic [9:0] cha = 10'h000;
  logic [9:0] chb = 10'h000;
  logic [15:0] rdata;
  logic [4:0] ga, gb;
  logic [9:0] pri_d, sec_d, cap_p, cap_s;
  logic pri_oe, sec_oe, lc, lcn, lc_oe;
  logic lc_last = 1'b0;
  logic [7:0] cnt;
  dabc_pkg::dabc_bus_t pri, sec;
  logic [15:0] expq[$];
  int checks = 0;
  int n_mismatch = 0;
  assign pri = {pri_oe, pri_d};
  assign sec = {sec_oe, sec_d};
  always #4 clk_i = ~clk_i;
  initial begin
    #5.3;
    forever #32 smp = ~smp;
  end
  dabc_top i_dabc_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr),
    .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .gain_a_o(ga),
    .gain_b_o(gb), .reference_powerdown_in_i(refpd), .smp_clk_i(smp),
    .standby_in_i(standby_in), .out_en_n_i(oen_n), .chan_a_i(cha),
    .chan_b_i(chb), .primary_out_bus_o(pri_d),
    .primary_out_bus_oe_o(pri_oe), .secondary_out_bus_o(sec_d),
    .secondary_out_bus_oe_o(sec_oe), .output_latch_clock_o(lc),
    .output_latch_clock_n_o(lcn), .output_latch_clock_oe_o(lc_oe));
  dabc_capture i_dabc_capture (.want_i(want), .out_en_n_o(oen_n),
    .lclk_i(lc), .lclk_oe_i(lc_oe), .pri_i(pri), .sec_i(sec),
    .cap_p_o(cap_p), .cap_s_o(cap_s), .cnt_o(cnt));
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wreg(logic [3:0] a, logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [3:0] a, logic [15:0] e);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    expq.push_back(e);
    @(posedge clk_i);
    rd <= 1'b0;
  endtask
  always @(posedge clk_i) begin
    if (rd_d) check("rdata", rdata, expq.pop_front());
    rd_d <= rd;
  end
  always @(posedge smp) begin
    if (lc_oe) begin
      check("lclk_n", lcn, !lc);
      check("lclk", lc, !lc_last);
    end
    lc_last <= lc;
  end
  task automatic steady(logic [4:0] c);
    logic [9:0] a;
    logic [9:0] p;
    a = 10'($urandom);
    @(posedge smp);
    cha <= a;
    chb <= a ^ 10'h155;
    wreg(4'h0, {11'h000, c});
    rreg(4'h0, {11'h000, c});
    repeat (32) @(posedge smp);
    p = pri_d;
    repeat (2) @(posedge smp);
    if (c[1] && !c[0]) begin
      // words alternate; which one comes first depends on entry phase
      check("pri_b", (p == a) ? pri_d : p, a ^ 10'h155);
      check("pri", (p == a) ? p : pri_d, a);
    end else begin
      check("pri", pri_d, a);
    end
    check("pri_oe", pri_oe, 1'b1);
    check("sec_oe", sec_oe, c[0]);
    if (c[0]) begin
      check("sec", sec_d, a ^ 10'h155);
      check("cap_s", cap_s, a ^ 10'h155);
    end
  endtask
  task automatic lat(output int d);
    logic [9:0] v;
    int n;
    v = ~pri_d;
    for (n = 0; n < 4 && lc !== 1'b1; n++) @(posedge smp);
    @(posedge smp);
    cha <= v;
    for (d = 0; d < 40 && pri_d !== v; d++) @(posedge smp);
    if (d == 40) begin
      n_mismatch++;
      results();
    end
  endtask
  task automatic cap(output logic [9:0] w);
    logic [7:0] c0;
    int n;
    c0 = cnt;
    for (n = 0; n < 20 && cnt == c0; n++) @(posedge smp);
    w = cap_p;
    if (cnt == c0) begin
      n_mismatch++;
      results();
    end
  endtask
  task automatic pins(logic s, logic w, logic r, logic e);
    @(posedge clk_i);
    standby_in <= s;
    want <= w;
    refpd <= r;
    repeat (8) @(posedge smp);
    check("pri_oe", pri_oe, e);
    check("sec_oe", sec_oe, e);
    check("lclk_oe", lc_oe, e);
    rreg(4'h2, {13'h0000, r, !w, s});
  endtask
  initial begin
    int i, d0, d1;
    logic [4:0] ea, eb;
    logic [9:0] w1, w2, a;
    void'($urandom(89386));
    repeat (4) @(posedge smp);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    rreg(4'h0, 16'h0000);
    rreg(4'h1, 16'h0000);
    for (i = 0; i < 6; i++) begin
      ea = (i == 0) ? 5'h1f : 5'($urandom);
      eb = (i == 0) ? 5'h00 : 5'($urandom);
      wreg(4'h1, {3'h0, eb, 3'h0, ea});
      #1;
      check("gain_a", ga, ea);
      check("gain_b", gb, eb);
      rreg(4'h1, {3'h0, eb, 3'h0, ea});
    end
    wreg(4'h7, 16'hffff);
    rreg(4'h7, 16'h0000);
    rreg(4'h1, {3'h0, eb, 3'h0, ea});
    steady(5'h00);
    steady(5'h01);
    steady(5'h04);
    steady(5'h09);
    steady(5'h10);
    steady(5'h00);
    lat(d0);
    steady(5'h04);
    lat(d1);
    check("lat_diff", 16'(d0 - d1), 16'h0004);
    steady(5'h02);
    a = cha;
    cap(w1);
    cap(w2);
    check("alt0", (w1 == a) ? w1 : w2, a);
    check("alt1", (w1 == a) ? w2 : w1, a ^ 10'h155);
    wreg(4'h0, 16'h0001);
    pins(1'b1, 1'b1, 1'b1, 1'b0);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    pins(1'b0, 1'b1, 1'b0, 1'b1);
    results();
  end
endmodule
`default_nettype wire
